//--- hw/sdpr_dual_port_ram.sv
// Notes on behaviour
// - 16K by 9 array, 8K when shallow
// - both ports reach any location together
// - inputs other than output enable and mode pins registered on each rising edge
// - chip enables deselect; read_write picks access
// - output enable floats data without clock
// - deselected port drops into standby
// - pipelined read data one cycle later
// - strobe low loads external address
// - advance low increments internal address
// - all high reuses internal address
// - clear low forces address zero
// - strobe and clear ignore chip enables
// - counter advances even when deselected
// - mode pin high pipelined, low flow
// - mode pins are static, not sampled
`timescale 1ns/100ps
`default_nettype none

module sdpr_dual_port_ram
#(
    parameter logic shallow_variant = 1'b0
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] chip_sel_active_low,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] chip_sel_active_high,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] port_read_write,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] output_enable_n,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] address_strobe_n,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] counter_advance_n,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] counter_clear_n,
    input wire logic [sdpr_pkg::SDPR_PORTS-1:0] output_mode_select,
    input wire sdpr_pkg::sdpr_addr_type [sdpr_pkg::SDPR_PORTS-1:0] port_address,
    input wire sdpr_pkg::sdpr_data_type [sdpr_pkg::SDPR_PORTS-1:0] port_data_in,
    output logic [sdpr_pkg::SDPR_PORTS-1:0][sdpr_pkg::SDPR_DATA_W-1:0] port_data_out,
    output logic [sdpr_pkg::SDPR_PORTS-1:0] port_data_oe,
    output logic [sdpr_pkg::SDPR_PORTS-1:0] port_standby
);
    import sdpr_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // shallow part leaves the top address bit unconnected, so it reads as zero
    function automatic sdpr_addr_type fold_addr(input sdpr_addr_type a);
        sdpr_addr_type r;
        r = a;
        if (shallow_variant)
        begin
            r[SDPR_TOP_BIT] = 1'b0;
        end
        return r;
    endfunction

    // address used by this edge: clear beats strobe beats advance beats hold
    function automatic sdpr_addr_type pick_addr(
        input logic clear_n,
        input logic strobe_n,
        input logic advance_n,
        input sdpr_addr_type ext,
        input sdpr_addr_type cur
    );
        sdpr_addr_type r;
        r = cur;
        if (!clear_n)
        begin
            r = SDPR_ADDR_RESET;
        end
        else if (!strobe_n)
        begin
            r = fold_addr(ext);
        end
        else if (!advance_n)
        begin
            r = fold_addr(cur + SDPR_ADDR_STEP);
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // storage and per-port state
    // ------------------------------------------------------------
    sdpr_data_type mem [SDPR_DEPTH];
    sdpr_addr_type addr_cnt [SDPR_PORTS];
    sdpr_addr_type next_addr [SDPR_PORTS];
    sdpr_data_type read_word [SDPR_PORTS];
    sdpr_data_type flow_data [SDPR_PORTS];
    sdpr_data_type pipe_data [SDPR_PORTS];
    logic [SDPR_PORTS-1:0] flow_drive;
    logic [SDPR_PORTS-1:0] pipe_drive;
    logic [SDPR_PORTS-1:0] selected;
    logic [SDPR_PORTS-1:0] wr_req;
    logic [SDPR_PORTS-1:0] rd_req;

    // ------------------------------------------------------------
    // input decode, evaluated at each rising edge
    // ------------------------------------------------------------

    // enables only gate the access; the counter path never looks at them
    always_comb
    begin
        for (int p = 0; p < SDPR_PORTS; p++)
        begin
            selected[p] = !chip_sel_active_low[p] && chip_sel_active_high[p];
            wr_req[p] = selected[p] && !port_read_write[p];
            rd_req[p] = selected[p] && port_read_write[p];
            next_addr[p] = pick_addr(counter_clear_n[p], address_strobe_n[p],
                counter_advance_n[p], port_address[p], addr_cnt[p]);
            read_word[p] = mem[next_addr[p]];
        end
    end

    // ------------------------------------------------------------
    // burst address counters
    // ------------------------------------------------------------

    // free of chip enables, so a deselected port still steps its burst
    always_ff @(posedge ref_clk)
    begin
        for (int p = 0; p < SDPR_PORTS; p++)
        begin
            if (!rst_n)
            begin
                addr_cnt[p] <= SDPR_ADDR_RESET;
            end
            else
            begin
                addr_cnt[p] <= next_addr[p];
            end
        end
    end

    // ------------------------------------------------------------
    // array write
    // ------------------------------------------------------------

    // both ports may write; a same-word collision leaves port 1's data,
    // which the masters must not rely on
    always_ff @(posedge ref_clk)
    begin
        for (int p = 0; p < SDPR_PORTS; p++)
        begin
            if (wr_req[p])
            begin
                mem[next_addr[p]] <= port_data_in[p];
            end
        end
    end

    // ------------------------------------------------------------
    // read path: flow register then pipeline register
    // ------------------------------------------------------------

    // a read sees the word as it stood before this edge's writes
    always_ff @(posedge ref_clk)
    begin
        for (int p = 0; p < SDPR_PORTS; p++)
        begin
            flow_data[p] <= read_word[p];
            pipe_data[p] <= flow_data[p];
        end
    end

    // drive flags follow the data through the same stages
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            flow_drive <= '0;
            pipe_drive <= '0;
        end
        else
        begin
            flow_drive <= rd_req;
            pipe_drive <= flow_drive;
        end
    end

    // standby tracks the last sampled enables of each port on its own
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            port_standby <= '1;
        end
        else
        begin
            port_standby <= ~selected;
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------

    // mode pins and output enable are used live; a mode change mid-burst
    // simply switches which stage is shown
    always_comb
    begin
        for (int p = 0; p < SDPR_PORTS; p++)
        begin
            port_data_out[p] = output_mode_select[p] ? pipe_data[p] : flow_data[p];
            port_data_oe[p] = !output_enable_n[p] &&
                (output_mode_select[p] ? pipe_drive[p] : flow_drive[p]);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    for (genvar g = 0; g < SDPR_PORTS; g++)
    begin : chk
        // ------------------------------------------------------------
        // checks: address counter
        // ------------------------------------------------------------
        // one property per counter mode, none gated by the enables; deselect_advance_a
        // adds a check that a deselected port still steps its counter
        clear_to_zero_a: assert property (
            !counter_clear_n[g] |=> addr_cnt[g] == SDPR_ADDR_RESET)
            else $error("counter clear did not give address zero");

        strobe_load_a: assert property (
            counter_clear_n[g] && !address_strobe_n[g]
            |=> addr_cnt[g] == fold_addr($past(port_address[g])))
            else $error("address strobe did not load external address");

        counter_advance_a: assert property (
            counter_clear_n[g] && address_strobe_n[g] && !counter_advance_n[g]
            |=> addr_cnt[g] == fold_addr($past(addr_cnt[g]) + SDPR_ADDR_STEP))
            else $error("counter did not advance by one");

        counter_hold_a: assert property (
            counter_clear_n[g] && address_strobe_n[g] && counter_advance_n[g]
            |=> $stable(addr_cnt[g]))
            else $error("held counter changed");

        deselect_advance_a: assert property (
            !selected[g] && counter_clear_n[g] && address_strobe_n[g]
            && !counter_advance_n[g] |=> addr_cnt[g] != $past(addr_cnt[g]))
            else $error("deselected port did not advance counter");

        // the top word is worked out from zero minus one, so the shallow
        // part is checked against its own top address
        counter_wrap_a: assert property (
            counter_clear_n[g] && address_strobe_n[g] && !counter_advance_n[g]
            && addr_cnt[g] == fold_addr(SDPR_ADDR_RESET - SDPR_ADDR_STEP)
            |=> addr_cnt[g] == SDPR_ADDR_RESET)
            else $error("counter did not wrap to zero");

        // ------------------------------------------------------------
        // checks: data pins
        // ------------------------------------------------------------
        // read checks keep the mode pin steady over the whole read, since a
        // mode change mid-read shows the other stage by design
        oe_float_a: assert property (
            output_enable_n[g] |-> !port_data_oe[g])
            else $error("data driven while output enable high");

        flow_read_a: assert property (
            rd_req[g] && !output_mode_select[g] ##1
            (!output_enable_n[g] && !output_mode_select[g])
            |-> port_data_oe[g] && port_data_out[g] == $past(read_word[g]))
            else $error("flow-through read data wrong");

        pipe_read_a: assert property (
            rd_req[g] && output_mode_select[g] ##1 output_mode_select[g] ##1
            (!output_enable_n[g] && output_mode_select[g])
            |-> port_data_oe[g] && port_data_out[g] == $past(read_word[g], 2))
            else $error("pipelined read data not one cycle later");

        deselect_float_a: assert property (
            !selected[g] && !output_mode_select[g] ##1 !output_mode_select[g]
            |-> !port_data_oe[g])
            else $error("deselected port drove data");

        deselect_pipe_a: assert property (
            !selected[g] && output_mode_select[g] ##1 output_mode_select[g]
            ##1 output_mode_select[g] |-> !port_data_oe[g])
            else $error("deselected pipelined port drove data");

        write_quiet_a: assert property (
            wr_req[g] && !output_mode_select[g] ##1 !output_mode_select[g]
            |-> !port_data_oe[g])
            else $error("write cycle drove read data");

        // ------------------------------------------------------------
        // checks: array and standby
        // ------------------------------------------------------------
        // the masters never write one word together, so this check only
        // fires on a lost write, not on a collision that they avoid
        write_lands_a: assert property (
            wr_req[g] |=> mem[$past(next_addr[g])] == $past(port_data_in[g]))
            else $error("written word not stored");

        standby_entry_a: assert property (
            !selected[g] |=> port_standby[g])
            else $error("deselected port not in standby");

        standby_leave_a: assert property (
            selected[g] |=> !port_standby[g])
            else $error("selected port still in standby");
    end

endmodule

`default_nettype wire

//--- hw/sdpr_pkg.sv
`default_nettype none

package sdpr_pkg;

    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam int SDPR_PORTS = 2;
    localparam int SDPR_ADDR_W = 14;
    localparam int SDPR_DATA_W = 9;
    localparam int SDPR_DEPTH = 16384;
    // highest address bit, left unconnected in the shallow variant
    localparam int SDPR_TOP_BIT = 13;

    // ------------------------------------------------------------
    // reset value and counter step
    // ------------------------------------------------------------
    localparam logic [SDPR_ADDR_W-1:0] SDPR_ADDR_RESET = 14'h0000;
    localparam logic [SDPR_ADDR_W-1:0] SDPR_ADDR_STEP = 14'h0001;

    typedef logic [SDPR_ADDR_W-1:0] sdpr_addr_type;
    typedef logic [SDPR_DATA_W-1:0] sdpr_data_type;

endpackage

`default_nettype wire

//--- dv/sdpr_master_model.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// one bus master standing on a single ram port
// ------------------------------------------------------------
module sdpr_master_model
(
    input wire logic ref_clk,
    output var logic [6:0] ctl,
    output var logic mode,
    output var sdpr_pkg::sdpr_addr_type addr,
    output var sdpr_pkg::sdpr_data_type din
);
    import sdpr_pkg::*;

    // ctl is {cs_low, cs_high, rw, oe_n, strobe_n, advance_n, clear_n}
    localparam logic [6:0] IDLE = 7'h57;

    // park deselected with the counter held
    initial
    begin
        ctl = IDLE;
        mode = 1'b0;
        addr = 14'h0000;
        din = 9'h155;
    end

    // the mode pin is a static strap chosen by the system
    task set_mode(input logic m);
        @(posedge ref_clk);
        mode <= m;
    endtask

    // one request, then back to idle; released lines show the inverse
    // so a stale value can never pass for a fresh one
    task op(input logic [6:0] c, input sdpr_addr_type a, input sdpr_data_type d);
        @(posedge ref_clk);
        ctl <= c;
        addr <= a;
        din <= d;
        @(posedge ref_clk);
        ctl <= IDLE;
        addr <= ~a;
        din <= ~d;
    endtask

    // present a request and leave it standing, so a pin that acts between
    // edges can be looked at after the edge; the next op takes over
    task op_keep(input logic [6:0] c, input sdpr_addr_type a, input sdpr_data_type d);
        @(posedge ref_clk);
        ctl <= c;
        addr <= a;
        din <= d;
        @(posedge ref_clk);
    endtask
endmodule

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import sdpr_pkg::*;

    localparam logic [6:0] RD_LOAD = 7'h33;
    localparam logic [6:0] WR_LOAD = 7'h23;
    localparam logic [6:0] WR_ADV = 7'h25;
    localparam logic [6:0] RD_ADV = 7'h35;
    localparam logic [6:0] RD_HOLD = 7'h37;
    localparam logic [6:0] RD_CLR = 7'h30;
    localparam logic [6:0] DS_ADV = 7'h75;
    localparam logic [6:0] DS_LOAD = 7'h53;
    localparam logic [6:0] OE_OFF = 7'h3b;

    logic ref_clk;
    logic rst_n;
    int err_count;
    int check_count;
    wire [6:0] ctl_a;
    wire [6:0] ctl_b;
    wire [1:0] mode;
    wire sdpr_addr_type [1:0] addr;
    wire sdpr_data_type [1:0] din;
    logic [1:0][SDPR_DATA_W-1:0] dout;
    logic [1:0] oe;
    logic [1:0] stby;

    // ------------------------------------------------------------
    // clock, masters and the ram
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    sdpr_master_model ma (.ref_clk(ref_clk), .ctl(ctl_a), .mode(mode[0]), .addr(addr[0]),
        .din(din[0]));
    sdpr_master_model mb (.ref_clk(ref_clk), .ctl(ctl_b), .mode(mode[1]), .addr(addr[1]),
        .din(din[1]));

    sdpr_dual_port_ram uut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .chip_sel_active_low({ctl_b[6], ctl_a[6]}),
        .chip_sel_active_high({ctl_b[5], ctl_a[5]}),
        .port_read_write({ctl_b[4], ctl_a[4]}),
        .output_enable_n({ctl_b[3], ctl_a[3]}),
        .address_strobe_n({ctl_b[2], ctl_a[2]}),
        .counter_advance_n({ctl_b[1], ctl_a[1]}),
        .counter_clear_n({ctl_b[0], ctl_a[0]}),
        .output_mode_select(mode),
        .port_address(addr),
        .port_data_in(din),
        .port_data_out(dout),
        .port_data_oe(oe),
        .port_standby(stby)
    );

    // ------------------------------------------------------------
    // compares and verdict
    // ------------------------------------------------------------
    task chk_data(input string what, input sdpr_data_type exp, input sdpr_data_type got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chk_flag(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task tally_and_finish;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // flow read on port a, judged in the cycle after the sampling edge
    task rd_a(input logic [6:0] c, input sdpr_addr_type a, input sdpr_data_type exp);
        ma.op(c, a, 9'h000);
        #1;
        chk_data("a_data", exp, dout[0]);
        chk_flag("a_oe", 1'b1, oe[0]);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task s_burst;
        ma.op(WR_LOAD, 14'h0010, 9'h1a5);
        ma.op(WR_ADV, 14'h2aaa, 9'h0f1);
        ma.op(WR_ADV, 14'h2aaa, 9'h0f2);
        rd_a(RD_LOAD, 14'h0010, 9'h1a5);
        rd_a(RD_ADV, 14'h2aaa, 9'h0f1);
        rd_a(RD_ADV, 14'h2aaa, 9'h0f2);
    endtask

    // both ports read one word on the same edge; b is pipelined
    task s_same_word;
        mb.set_mode(1'b1);
        fork
            ma.op(RD_LOAD, 14'h0011, 9'h000);
            mb.op(RD_LOAD, 14'h0011, 9'h000);
        join
        #1;
        chk_data("a_data", 9'h0f1, dout[0]);
        chk_flag("b_oe", 1'b0, oe[1]);
        @(posedge ref_clk);
        #1;
        chk_data("b_data", 9'h0f1, dout[1]);
        chk_flag("b_oe", 1'b1, oe[1]);
    endtask

    task s_counter;
        ma.op(WR_LOAD, 14'h3fff, 9'h155);
        ma.op(WR_LOAD, 14'h0000, 9'h0aa);
        ma.op(WR_LOAD, 14'h0021, 9'h066);
        rd_a(RD_LOAD, 14'h3fff, 9'h155);
        rd_a(RD_ADV, 14'h1111, 9'h0aa);
        rd_a(RD_HOLD, 14'h2bcd, 9'h0aa);
        ma.op(DS_LOAD, 14'h0020, 9'h1ff);
        ma.op(DS_ADV, 14'h0000, 9'h000);
        #1;
        chk_flag("a_oe", 1'b0, oe[0]);
        rd_a(RD_HOLD, 14'h0000, 9'h066);
        rd_a(RD_CLR, 14'h1234, 9'h0aa);
    endtask

    // output enable stays high after the read edge, then a read with it low
    task s_oe_standby;
        ma.op_keep(OE_OFF, 14'h0021, 9'h000);
        #1;
        chk_flag("a_oe", 1'b0, oe[0]);
        chk_flag("a_standby", 1'b0, stby[0]);
        rd_a(RD_HOLD, 14'h0000, 9'h066);
        @(posedge ref_clk);
        #1;
        chk_flag("a_standby", 1'b1, stby[0]);
    endtask

    // reset in mid-run: the counter must go back to word zero
    task s_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk_flag("a_standby", 1'b1, stby[0]);
        chk_flag("a_oe", 1'b0, oe[0]);
        rd_a(RD_HOLD, 14'h1234, 9'h0aa);
    endtask

    // ------------------------------------------------------------
    // main sequence; the masters never write one word together
    // ------------------------------------------------------------
    initial
    begin
        err_count = 0;
        check_count = 0;
        rst_n = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        chk_flag("b_standby", 1'b1, stby[1]);
        chk_flag("b_oe", 1'b0, oe[1]);
        s_burst();
        s_same_word();
        s_counter();
        s_oe_standby();
        s_reset();
        tally_and_finish();
    end

    // a hang counts as a mismatch
    initial
    begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
